/* hdl/dps_pkg.sv */
package dps_pkg;

    // Core clock rate and the cycles in one microsecond.
    localparam int CLK_HZ     = 50_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;

    // Phase and conversion times in microseconds.
    localparam int T_ZI_US         = 40_000;
    localparam int T_AZ_US         = 25_000;
    localparam int T_INT_US        = 100_000;
    localparam int T_REFERENCE_DISCHARGE_PHASE_US       = 165_000;
    localparam int T_REFERENCE_DISCHARGE_PHASE_SHORT_US = 82_500;
    localparam int T_CAP_LOW_US    = 330_000;
    localparam int T_CAP_MID_US    = 660_000;
    localparam int T_CAP_HIGH_US   = 1_320_000;
    localparam int T_CAP_TOP_US    = 6_600_000;
    localparam int T_DUTY_US       = 660_000;
    localparam int T_FREQ_LOW_US   = 500_000;
    localparam int T_FREQ_US       = 1_050_000;

    // The same times in clock cycles; all fit comfortably in 32 bits.
    localparam int CYC_ZI         = T_ZI_US * CYC_PER_US;
    localparam int CYC_AZ         = T_AZ_US * CYC_PER_US;
    localparam int CYC_INT        = T_INT_US * CYC_PER_US;
    localparam int CYC_REFERENCE_DISCHARGE_PHASE       = T_REFERENCE_DISCHARGE_PHASE_US * CYC_PER_US;
    localparam int CYC_REFERENCE_DISCHARGE_PHASE_SHORT = T_REFERENCE_DISCHARGE_PHASE_SHORT_US * CYC_PER_US;
    localparam int CYC_CAP_LOW    = T_CAP_LOW_US * CYC_PER_US;
    localparam int CYC_CAP_MID    = T_CAP_MID_US * CYC_PER_US;
    localparam int CYC_CAP_HIGH   = T_CAP_HIGH_US * CYC_PER_US;
    localparam int CYC_CAP_TOP    = T_CAP_TOP_US * CYC_PER_US;
    localparam int CYC_DUTY       = T_DUTY_US * CYC_PER_US;
    localparam int CYC_FREQ_LOW   = T_FREQ_LOW_US * CYC_PER_US;
    localparam int CYC_FREQ       = T_FREQ_US * CYC_PER_US;

    // Timer advance per clock: normal, fast settling (x4) and frequency settling (x10).
    localparam logic [3:0] STEP_NORMAL = 4'h1;
    localparam logic [3:0] STEP_VR     = 4'h4;
    localparam logic [3:0] STEP_FREQ   = 4'ha;

    // Range codes that steer prefixes and times.
    localparam logic [2:0] RNG_MV       = 3'h4;
    localparam logic [2:0] RNG_CAP_UF   = 3'h3;
    localparam logic [2:0] RNG_CAP_MF   = 3'h6;
    localparam logic [2:0] RNG_CAP_MID  = 3'h4;
    localparam logic [2:0] RNG_CAP_TOP  = 3'h7;
    localparam logic [2:0] RNG_OHM_MEG  = 3'h4;
    localparam logic [2:0] RNG_OHM_MAX  = 3'h5;
    localparam logic [2:0] RNG_FREQ_LOW = 3'h0;
    localparam logic [2:0] RNG_ADP_MAX  = 3'h3;

    // Reset value of the annunciator register.
    localparam logic [30:0] ANN_RST = 31'h0;

    // Measurement modes as presented on the mode pins.
    typedef enum logic [3:0] {
        MODE_VOLT      = 4'h0,
        MODE_VOLT_2R   = 4'h1,
        MODE_CUR_METER = 4'h2,
        MODE_CUR_CMAN  = 4'h3,
        MODE_CUR_CAUTO = 4'h4,
        MODE_OHM       = 4'h5,
        MODE_CONT      = 4'h6,
        MODE_DIODE     = 4'h7,
        MODE_FREQ      = 4'h8,
        MODE_DUTY      = 4'h9,
        MODE_CAP       = 4'ha,
        MODE_TEMP      = 4'hb,
        MODE_ADP       = 4'hc
    } dps_mode_e;

    // Converter phases; the gate phase serves counting modes.
    typedef enum logic [2:0] {
        PH_CLEAR = 3'h0,
        PH_NULL  = 3'h1,
        PH_INTEG = 3'h2,
        PH_DISCH = 3'h3,
        PH_GATE  = 3'h4
    } dps_phase_e;

endpackage : dps_pkg

/* hdl/dps_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for a group of pin inputs.
module dps_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff; // First stage, read only by the second.

    // Both stages clear on reset so decode logic sees known levels.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= '0;
            dout    <= '0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule : dps_sync

/* hdl/dps_phase_timer.sv */
`timescale 1ns/100ps
// Phase timer that advances by a variable step each clock.
module dps_phase_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        restart,
    input  wire logic [3:0]  step,
    input  wire logic [31:0] limit,
    output logic             done
);
    logic [31:0] acc_ff;  // Elapsed weighted cycles in this phase.
    logic [31:0] nxt_acc; // Accumulator after this clock.

    // A larger step shortens the phase without changing its nominal length.
    assign nxt_acc = acc_ff + {28'h0, step};
    assign done    = !restart && (nxt_acc >= limit);

    // Restart and completion both start the next phase from zero.
    always_ff @(posedge clk) begin
        if (rst || restart || done) begin
            acc_ff <= 32'h0;
        end else begin
            acc_ff <= nxt_acc;
        end
    end
endmodule : dps_phase_timer

/* hdl/dps_top.sv */
`timescale 1ns/100ps
module dps_top #(
    // Every time scales from the clear phase, so one value shortens them all alike.
    parameter int P_ZI         = dps_pkg::CYC_ZI,
    parameter int P_AZ         = int'(64'(P_ZI) * dps_pkg::T_AZ_US / dps_pkg::T_ZI_US),
    parameter int P_INT        = int'(64'(P_ZI) * dps_pkg::T_INT_US / dps_pkg::T_ZI_US),
    parameter int P_REFERENCE_DISCHARGE_PHASE       = int'(64'(P_ZI) * dps_pkg::T_REFERENCE_DISCHARGE_PHASE_US / dps_pkg::T_ZI_US),
    parameter int P_REFERENCE_DISCHARGE_PHASE_SHORT = int'(64'(P_ZI) * dps_pkg::T_REFERENCE_DISCHARGE_PHASE_SHORT_US / dps_pkg::T_ZI_US),
    parameter int P_CAP_LOW    = int'(64'(P_ZI) * dps_pkg::T_CAP_LOW_US / dps_pkg::T_ZI_US),
    parameter int P_CAP_MID    = int'(64'(P_ZI) * dps_pkg::T_CAP_MID_US / dps_pkg::T_ZI_US),
    parameter int P_CAP_HIGH   = int'(64'(P_ZI) * dps_pkg::T_CAP_HIGH_US / dps_pkg::T_ZI_US),
    parameter int P_CAP_TOP    = int'(64'(P_ZI) * dps_pkg::T_CAP_TOP_US / dps_pkg::T_ZI_US),
    parameter int P_DUTY       = int'(64'(P_ZI) * dps_pkg::T_DUTY_US / dps_pkg::T_ZI_US),
    parameter int P_FREQ_LOW   = int'(64'(P_ZI) * dps_pkg::T_FREQ_LOW_US / dps_pkg::T_ZI_US),
    parameter int P_FREQ       = int'(64'(P_ZI) * dps_pkg::T_FREQ_US / dps_pkg::T_ZI_US)
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [3:0] MODE,
    input  wire logic [2:0] RANGE,
    input  wire logic       AC_SEL,
    input  wire logic       AUTO_RANGE,
    input  wire logic       RANGE_SETTLING,
    input  wire logic       CUR_MICRO,
    input  wire logic       CUR_MILLI,
    input  wire logic       HOLD_EN,
    input  wire logic       OFFSET_SUBTRACT_MODE,
    input  wire logic       MAXMIN_EN,
    input  wire logic       ZERO_EN,
    input  wire logic       TEMP_CELSIUS,
    input  wire logic       AUTO_SHUTOFF_ENABLED,
    input  wire logic       SERIAL_EN,
    output logic            INTEGRATOR_CLEAR_PHASE,
    output logic            OFFSET_NULL_PHASE,
    output logic            INTEGRATE_PHASE,
    output logic            REFERENCE_DISCHARGE_PHASE,
    output logic            MEASURE_GATE,
    output logic            CONV_DONE,
    output logic            FAST_CLOCK,
    output logic            ANN_VOLT,
    output logic            ANN_AMP,
    output logic            ANN_FARAD,
    output logic            ANN_OHM,
    output logic            ANN_CONT,
    output logic            ANN_DIODE,
    output logic            ANN_PCT,
    output logic            ANN_HZ,
    output logic            ANN_DC,
    output logic            ANN_AC,
    output logic            ANN_AUTO,
    output logic            ANN_FIXED_RANGE_MODE,
    output logic            ANN_HOLD,
    output logic            ANN_OFFSET_SUBTRACT,
    output logic            ANN_MAXMIN,
    output logic            ANN_ZERO,
    output logic            ANN_CAP_MILLI_PREFIX,
    output logic            ANN_CAP_MICRO,
    output logic            ANN_NANO,
    output logic            ANN_VA_MILLI_PREFIX,
    output logic            ANN_CUR_MICRO,
    output logic            ANN_MEGA,
    output logic            ANN_KILO,
    output logic            ANN_CELSIUS,
    output logic            ANN_FAHRENHEIT,
    output logic            ANN_AUTO_SHUTOFF,
    output logic            ANN_SERIAL,
    output logic [3:0]      ANN_ADAPTER
);

    // Synchronised copies of all pin inputs.
    logic [18:0] pin_s;
    dps_sync #(.W(19)) u_sync (
        .clk  (CLK),
        .rst  (RST),
        .din  ({MODE, RANGE, AC_SEL, AUTO_RANGE, RANGE_SETTLING, CUR_MICRO, CUR_MILLI,
                HOLD_EN, OFFSET_SUBTRACT_MODE, MAXMIN_EN, ZERO_EN, TEMP_CELSIUS,
                AUTO_SHUTOFF_ENABLED, SERIAL_EN}),
        .dout (pin_s)
    );

    // Unpacked synchronised fields.
    dps_pkg::dps_mode_e mode_s;     // Measurement mode.
    logic [2:0]         range_s;    // Full-scale range code.
    logic               ac_s;       // AC coupling selected.
    logic               auto_s;     // Automatic ranging active.
    logic               settle_s;   // Auto-ranger is changing range.
    logic               umicro_s;   // Current range is in microamperes.
    logic               umilli_s;   // Current range is in milliamperes.
    logic [6:0]         flags_s;    // Push functions and enables.
    assign mode_s   = dps_pkg::dps_mode_e'(pin_s[18:15]);
    assign range_s  = pin_s[14:12];
    assign ac_s     = pin_s[11];
    assign auto_s   = pin_s[10];
    assign settle_s = pin_s[9];
    assign umicro_s = pin_s[8];
    assign umilli_s = pin_s[7];
    assign flags_s  = pin_s[6:0];

    // Mode class decode shared by timing and annunciators.
    logic is_volt;    // Any voltage mode.
    logic is_cur;     // Any current mode.
    logic gate_mode;  // Counting modes use one gate window, not four phases.
    logic reference_discharge_phase_short; // Modes whose discharge phase is halved.
    assign is_volt    = (mode_s == dps_pkg::MODE_VOLT) || (mode_s == dps_pkg::MODE_VOLT_2R);
    assign is_cur     = (mode_s == dps_pkg::MODE_CUR_METER) ||
                        (mode_s == dps_pkg::MODE_CUR_CMAN)  ||
                        (mode_s == dps_pkg::MODE_CUR_CAUTO);
    assign gate_mode  = (mode_s == dps_pkg::MODE_CAP) || (mode_s == dps_pkg::MODE_DUTY) ||
                        (mode_s == dps_pkg::MODE_FREQ);
    assign reference_discharge_phase_short = (mode_s == dps_pkg::MODE_VOLT_2R)   ||
                        (mode_s == dps_pkg::MODE_CUR_METER) ||
                        (mode_s == dps_pkg::MODE_CUR_CAUTO) ||
                        (mode_s == dps_pkg::MODE_CONT)      ||
                        (mode_s == dps_pkg::MODE_DIODE);

    // Phase state and the previous mode and range for change detection.
    dps_pkg::dps_phase_e phase_ff;
    dps_pkg::dps_phase_e nxt_phase;
    logic [6:0]          sel_prev_ff; // Mode and range seen last clock.
    logic                tmr_done;    // Current phase has run its time.
    logic                restart;     // Abandon the conversion and begin again.

    // A new mode or range makes the running conversion meaningless, so it
    // restarts; a phase that does not fit the mode also forces a restart.
    assign restart = (sel_prev_ff != {mode_s, range_s}) ||
                     (gate_mode != (phase_ff == dps_pkg::PH_GATE));

    // Speed-up while the auto-ranger settles; the frequency case takes priority.
    logic fast_vr;
    logic fast_fq;
    logic [3:0] tmr_step;
    assign fast_vr  = auto_s && settle_s && (mode_s == dps_pkg::MODE_OHM ||
                      (is_volt && !ac_s));
    assign fast_fq  = auto_s && settle_s && (mode_s == dps_pkg::MODE_FREQ);
    assign tmr_step = fast_fq ? dps_pkg::STEP_FREQ :
                      fast_vr ? dps_pkg::STEP_VR : dps_pkg::STEP_NORMAL;
    assign FAST_CLOCK = fast_fq || fast_vr;

    // Gate window length for counting modes.
    logic [31:0] cap_limit;
    logic [31:0] gate_limit;
    logic [31:0] reference_discharge_phase_limit;
    logic [31:0] phase_limit;
    assign cap_limit  = (range_s <  dps_pkg::RNG_CAP_MID) ? 32'(P_CAP_LOW)  :
                        (range_s == dps_pkg::RNG_CAP_MID) ? 32'(P_CAP_MID)  :
                        (range_s == dps_pkg::RNG_CAP_TOP) ? 32'(P_CAP_TOP)  :
                                                            32'(P_CAP_HIGH);
    assign gate_limit = (mode_s == dps_pkg::MODE_CAP)  ? cap_limit :
                        (mode_s == dps_pkg::MODE_DUTY) ? 32'(P_DUTY) :
                        (range_s == dps_pkg::RNG_FREQ_LOW) ? 32'(P_FREQ_LOW) :
                                                         32'(P_FREQ);
    assign reference_discharge_phase_limit = reference_discharge_phase_short ? 32'(P_REFERENCE_DISCHARGE_PHASE_SHORT) : 32'(P_REFERENCE_DISCHARGE_PHASE);
    // Length of whichever phase is running now.
    assign phase_limit = (phase_ff == dps_pkg::PH_CLEAR) ? 32'(P_ZI)  :
                         (phase_ff == dps_pkg::PH_NULL)  ? 32'(P_AZ)  :
                         (phase_ff == dps_pkg::PH_INTEG) ? 32'(P_INT) :
                         (phase_ff == dps_pkg::PH_DISCH) ? reference_discharge_phase_limit : gate_limit;

    dps_phase_timer u_tmr (
        .clk     (CLK),
        .rst     (RST),
        .restart (restart),
        .step    (tmr_step),
        .limit   (phase_limit),
        .done    (tmr_done)
    );

    // Phase successor: the four phases rotate; the gate window repeats.
    always_comb begin
        nxt_phase = phase_ff;
        if (restart) begin
            nxt_phase = gate_mode ? dps_pkg::PH_GATE : dps_pkg::PH_CLEAR;
        end else if (tmr_done) begin
            case (phase_ff)
                dps_pkg::PH_CLEAR: nxt_phase = dps_pkg::PH_NULL;
                dps_pkg::PH_NULL:  nxt_phase = dps_pkg::PH_INTEG;
                dps_pkg::PH_INTEG: nxt_phase = dps_pkg::PH_DISCH;
                dps_pkg::PH_DISCH: nxt_phase = dps_pkg::PH_CLEAR;
                dps_pkg::PH_GATE:  nxt_phase = dps_pkg::PH_GATE;
                default:           nxt_phase = dps_pkg::PH_CLEAR;
            endcase
        end
    end

    // Phase register, change detector and end-of-conversion pulse.
    always_ff @(posedge CLK) begin
        if (RST) begin
            phase_ff    <= dps_pkg::PH_CLEAR;
            sel_prev_ff <= 7'h0;
            CONV_DONE   <= 1'b0;
        end else begin
            phase_ff    <= nxt_phase;
            sel_prev_ff <= {mode_s, range_s};
            CONV_DONE   <= tmr_done && (phase_ff == dps_pkg::PH_DISCH ||
                                        phase_ff == dps_pkg::PH_GATE);
        end
    end

    // Phase strobes to the analog switches are decodes of the phase register.
    assign INTEGRATOR_CLEAR_PHASE    = (phase_ff == dps_pkg::PH_CLEAR);
    assign OFFSET_NULL_PHASE         = (phase_ff == dps_pkg::PH_NULL);
    assign INTEGRATE_PHASE           = (phase_ff == dps_pkg::PH_INTEG);
    assign REFERENCE_DISCHARGE_PHASE = (phase_ff == dps_pkg::PH_DISCH);
    assign MEASURE_GATE              = (phase_ff == dps_pkg::PH_GATE);

    // Annunciator decode. The panel driver samples these, so they are
    // registered to keep decode glitches off the glass.
    logic        m_cap;
    logic        m_ohm;
    logic        m_temp;
    logic [3:0]  adp_onehot;
    logic [30:0] nxt_ann;
    logic [30:0] ann_ff;
    assign m_cap  = (mode_s == dps_pkg::MODE_CAP);
    assign m_ohm  = (mode_s == dps_pkg::MODE_OHM);
    assign m_temp = (mode_s == dps_pkg::MODE_TEMP);
    // Range code 0 is the highest-numbered adapter and code 3 the lowest.
    assign adp_onehot = (mode_s == dps_pkg::MODE_ADP && range_s <= dps_pkg::RNG_ADP_MAX) ?
                        (4'h8 >> range_s[1:0]) : 4'h0;
    assign nxt_ann = {
        is_volt || mode_s == dps_pkg::MODE_DIODE,
        is_cur,
        m_cap,
        m_ohm || mode_s == dps_pkg::MODE_CONT,
        mode_s == dps_pkg::MODE_CONT,
        mode_s == dps_pkg::MODE_DIODE,
        mode_s == dps_pkg::MODE_DUTY,
        mode_s == dps_pkg::MODE_FREQ,
        (is_volt || is_cur) && !ac_s,
        (is_volt || is_cur) && ac_s,
        auto_s,
        !auto_s,
        flags_s[6:3],
        m_cap && range_s >= dps_pkg::RNG_CAP_MF,
        m_cap && range_s >= dps_pkg::RNG_CAP_UF && range_s < dps_pkg::RNG_CAP_MF,
        m_cap && range_s < dps_pkg::RNG_CAP_UF,
        (is_volt && range_s == dps_pkg::RNG_MV) || (is_cur && umilli_s && !umicro_s),
        is_cur && umicro_s,
        m_ohm && range_s >= dps_pkg::RNG_OHM_MEG && range_s <= dps_pkg::RNG_OHM_MAX,
        m_ohm && range_s != 3'h0 && range_s < dps_pkg::RNG_OHM_MEG,
        m_temp && flags_s[2],
        m_temp && !flags_s[2],
        flags_s[1:0],
        adp_onehot
    };

    // Annunciator register; all segments dark after reset.
    always_ff @(posedge CLK) begin
        if (RST) begin
            ann_ff <= dps_pkg::ANN_RST;
        end else begin
            ann_ff <= nxt_ann;
        end
    end

    assign {ANN_VOLT, ANN_AMP, ANN_FARAD, ANN_OHM, ANN_CONT, ANN_DIODE, ANN_PCT, ANN_HZ,
            ANN_DC, ANN_AC, ANN_AUTO, ANN_FIXED_RANGE_MODE, ANN_HOLD, ANN_OFFSET_SUBTRACT,
            ANN_MAXMIN, ANN_ZERO, ANN_CAP_MILLI_PREFIX, ANN_CAP_MICRO, ANN_NANO,
            ANN_VA_MILLI_PREFIX, ANN_CUR_MICRO, ANN_MEGA, ANN_KILO, ANN_CELSIUS,
            ANN_FAHRENHEIT, ANN_AUTO_SHUTOFF, ANN_SERIAL, ANN_ADAPTER} = ann_ff;

    // Checks on the sequencer and the panel decode.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    phase_rotate_a: assert property (
        (!restart && tmr_done && phase_ff == dps_pkg::PH_INTEG)
        |=> REFERENCE_DISCHARGE_PHASE ##0 $past(INTEGRATE_PHASE))
        else $error("integration not followed by discharge");
    phase_exclusive_a: assert property (
        $onehot({INTEGRATOR_CLEAR_PHASE, OFFSET_NULL_PHASE, INTEGRATE_PHASE,
                 REFERENCE_DISCHARGE_PHASE, MEASURE_GATE}))
        else $error("phase strobes not exclusive");
    normal_reference_discharge_phase_len_a: assert property (
        (phase_ff == dps_pkg::PH_DISCH && mode_s == dps_pkg::MODE_OHM)
        |-> phase_limit == 32'(P_REFERENCE_DISCHARGE_PHASE))
        else $error("discharge length wrong in resistance mode");
    short_reference_discharge_phase_len_a: assert property (
        (phase_ff == dps_pkg::PH_DISCH && mode_s == dps_pkg::MODE_DIODE)
        |-> phase_limit == 32'(P_REFERENCE_DISCHARGE_PHASE_SHORT))
        else $error("discharge not shortened in diode mode");
    volt_fast_step_a: assert property (
        (auto_s && settle_s && mode_s == dps_pkg::MODE_VOLT && !ac_s)
        |-> tmr_step == 4'h4 && FAST_CLOCK)
        else $error("settling voltage not four times faster");
    cap_top_time_a: assert property (
        (MEASURE_GATE && m_cap && range_s == 3'h7) |-> phase_limit == 32'(P_CAP_TOP))
        else $error("largest capacitance range time wrong");
    duty_time_a: assert property (
        (MEASURE_GATE && mode_s == dps_pkg::MODE_DUTY) |-> phase_limit == 32'(P_DUTY))
        else $error("duty conversion time wrong");
    freq_cycle_a: assert property (
        (MEASURE_GATE && mode_s == dps_pkg::MODE_FREQ && range_s != 3'h0)
        |-> phase_limit == 32'(P_FREQ))
        else $error("frequency cycle time wrong");
    freq_fast_step_a: assert property (
        (auto_s && settle_s && mode_s == dps_pkg::MODE_FREQ) |-> tmr_step == 4'ha)
        else $error("settling frequency not ten times faster");
    cap_prefix_a: assert property (
        (m_cap && $stable(range_s)) |=> $onehot({ANN_CAP_MILLI_PREFIX, ANN_CAP_MICRO, ANN_NANO}))
        else $error("capacitance prefix not unique");
    farad_lamp_a: assert property (
        m_cap |=> ANN_FARAD && !ANN_VOLT && !ANN_AMP)
        else $error("farad lamp wrong");
    adapter_lamp_a: assert property (
        ##1 $onehot0(ANN_ADAPTER) && (ANN_ADAPTER == 4'h0 || $past(mode_s) == dps_pkg::MODE_ADP))
        else $error("adapter lamps wrong");

    cover_conv_done: cover property (CONV_DONE && $past(REFERENCE_DISCHARGE_PHASE));
    cover_gate_done: cover property (CONV_DONE && MEASURE_GATE);
    cover_fast_volt: cover property (fast_vr && tmr_done);

endmodule : dps_top

/* verification/dps_front_model.sv */
`timescale 1ns/100ps
// Integrator stand-in: it times the gap between conversion-done pulses.
module dps_front_model (
    input  wire logic clk,
    input  wire logic done,
    output int        per
);
    int cnt = 0; // Cycles since the last pulse.
    // Latched on each pulse, so a restart spoils one sample only.
    always @(posedge clk) begin
        if (done) begin
            per <= cnt;
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : dps_front_model

/* verification/tb_top.sv */
`timescale 1ns/100ps
// Bench: a timing table over modes and ranges, then random lamp sweeps.
module tb_top;
    logic CLK = 0, RST = 1, AC_SEL = 0, AUTO_RANGE = 0, RANGE_SETTLING = 0, CUR_MICRO = 0;
    logic CUR_MILLI = 0, HOLD_EN = 0, OFFSET_SUBTRACT_MODE = 0, MAXMIN_EN = 0, ZERO_EN = 0;
    logic TEMP_CELSIUS = 0, AUTO_SHUTOFF_ENABLED = 0, SERIAL_EN = 0;
    logic [3:0] MODE = 4'h0, ANN_ADAPTER;
    logic [2:0] RANGE = 3'h0;
    logic INTEGRATOR_CLEAR_PHASE, OFFSET_NULL_PHASE, INTEGRATE_PHASE, REFERENCE_DISCHARGE_PHASE;
    logic MEASURE_GATE, CONV_DONE, FAST_CLOCK, ANN_VOLT, ANN_AMP, ANN_FARAD, ANN_OHM, ANN_CONT;
    logic ANN_DIODE, ANN_PCT, ANN_HZ, ANN_DC, ANN_AC, ANN_AUTO, ANN_FIXED_RANGE_MODE, ANN_HOLD;
    logic ANN_OFFSET_SUBTRACT, ANN_MAXMIN, ANN_ZERO, ANN_CAP_MILLI_PREFIX, ANN_CAP_MICRO, ANN_NANO;
    logic ANN_VA_MILLI_PREFIX, ANN_CUR_MICRO, ANN_MEGA, ANN_KILO, ANN_CELSIUS, ANN_FAHRENHEIT;
    logic ANN_AUTO_SHUTOFF, ANN_SERIAL;
    int error_cnt = 0, compares = 0, cyc = 0, per;
    logic [31:0] lfsr = 32'ha75dc367; // Fixed seed keeps runs repeatable.
    // Entry = mode*100 + range*10 + settling; the period follows from the rules.
    int tbl [29] = '{0, 300, 500, 1200, 100, 200, 400, 600, 700, 1, 511, 1000, 1010, 1020,
        1030, 1040, 1050, 1060, 1070, 900, 800, 810, 820, 830, 840, 850, 860, 811, 801};
    // One short clear-phase count scales every other time, keeping the run brief.
    localparam int ZI = 16;
    dps_top #(.P_ZI(ZI)) dut (.*);
    dps_front_model model (.clk(CLK), .done(CONV_DONE), .per(per));
    initial begin
        forever #10 CLK = ~CLK;
    end
    // Watchdog: the planned run needs about half of this ceiling.
    always @(negedge CLK) begin
        cyc++;
        if (cyc == 60000) chk(32'h0, 32'h1);
        if (cyc == 60000) report_and_stop();
    end
    function automatic logic [31:0] next_rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rnd
    // Expected lamps, in the order of the concatenation checked in the sweep.
    function automatic logic [16:0] lamps(input logic [3:0] m, input logic [2:0] r);
        return {m < 4'h2 || m == 4'h7, m inside {[4'h2:4'h4]}, m == 4'ha,
            m inside {[4'h5:4'h6]}, m == 4'h6, m == 4'h7, m == 4'h9, m == 4'h8,
            m == 4'ha && r > 3'h5, m == 4'ha && r inside {[3'h3:3'h5]}, m == 4'ha && r < 3'h3,
            m == 4'hb && TEMP_CELSIUS, m == 4'hb && !TEMP_CELSIUS,
            (m == 4'hc && r < 3'h4) ? 4'h8 >> r : 4'h0};
    endfunction : lamps
    // Cycles for a time in microseconds at the bench scale, with step st per clock.
    function automatic int sc(input int us, input int st);
        return (us * ZI / 40000 + st - 1) / st;
    endfunction : sc
    // Expected spacing of conversion-done pulses for one operating point.
    function automatic int exp_per(input int m, input int r, input int s);
        int st;
        st = (s == 0) ? 1 : (m == 8) ? 10 : 4;
        if (m == 10) return sc(r < 4 ? 330000 : r == 4 ? 660000 : r == 7 ? 6600000 : 1320000, 1);
        if (m == 9) return sc(660000, 1);
        if (m == 8) return sc(r == 0 ? 500000 : 1050000, st);
        return sc(40000, st) + sc(25000, st) + sc(100000, st) +
            sc(m inside {1, 2, 4, 6, 7} ? 82500 : 165000, st);
    endfunction : exp_per
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Sets one operating point and checks the spacing of conversion-done pulses.
    task automatic run(input int v);
        int n = 0;
        MODE = 4'(v / 100);
        RANGE = 3'(v / 10 % 10);
        RANGE_SETTLING = 1'(v % 10);
        AUTO_RANGE = RANGE_SETTLING;
        repeat (4) @(negedge CLK);
        // Three pulses, so the last gap is a whole cycle after the restart.
        while (n < 3 && cyc < 60000) begin
            @(negedge CLK);
            n += int'(CONV_DONE);
        end
        @(negedge CLK);
        chk(per, 32'(exp_per(v / 100, v / 10 % 10, v % 10)));
        chk(FAST_CLOCK, RANGE_SETTLING);
        // Just after a pulse a four-phase conversion is back in its clear phase.
        chk({INTEGRATOR_CLEAR_PHASE, OFFSET_NULL_PHASE, INTEGRATE_PHASE, REFERENCE_DISCHARGE_PHASE,
            MEASURE_GATE}, (MODE > 4'h7 && MODE < 4'hb) ? 32'h1 : 32'h10);
    endtask : run
    initial begin
        repeat (3) @(negedge CLK);
        RST = 1'b0;
        foreach (tbl[i]) begin
            run(tbl[i]);
        end
        RANGE_SETTLING = 1'b0;
        for (int k = 0; k < 300; k++) begin
            lfsr = next_rnd(lfsr);
            {AC_SEL, AUTO_RANGE, CUR_MICRO, CUR_MILLI, HOLD_EN, OFFSET_SUBTRACT_MODE, MAXMIN_EN,
                ZERO_EN, TEMP_CELSIUS, AUTO_SHUTOFF_ENABLED, SERIAL_EN, RANGE} = lfsr[13:0];
            MODE = (k < 13) ? k[3:0] : 4'(lfsr[31:16] % 13);
            repeat (4) @(negedge CLK);
            chk({ANN_VOLT, ANN_AMP, ANN_FARAD, ANN_OHM, ANN_CONT, ANN_DIODE, ANN_PCT, ANN_HZ,
                ANN_CAP_MILLI_PREFIX, ANN_CAP_MICRO, ANN_NANO, ANN_CELSIUS, ANN_FAHRENHEIT,
                ANN_ADAPTER}, lamps(MODE, RANGE));
            chk({ANN_DC, ANN_AC}, (MODE < 4'h5) ? {!AC_SEL, AC_SEL} : 2'h0);
            chk({ANN_AUTO, ANN_FIXED_RANGE_MODE, ANN_HOLD, ANN_OFFSET_SUBTRACT, ANN_MAXMIN,
                ANN_ZERO, ANN_AUTO_SHUTOFF, ANN_SERIAL}, {AUTO_RANGE, !AUTO_RANGE, HOLD_EN,
                OFFSET_SUBTRACT_MODE, MAXMIN_EN, ZERO_EN, AUTO_SHUTOFF_ENABLED,
                SERIAL_EN});
            chk({ANN_VA_MILLI_PREFIX, ANN_CUR_MICRO, ANN_MEGA, ANN_KILO},
                {(MODE < 4'h2 && RANGE == 3'h4) ||
                (MODE inside {[4'h2:4'h4]} && CUR_MILLI && !CUR_MICRO),
                MODE inside {[4'h2:4'h4]} && CUR_MICRO,
                MODE == 4'h5 && RANGE inside {[3'h4:3'h5]},
                MODE == 4'h5 && RANGE inside {[3'h1:3'h3]}});
        end
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("compares=%0d errors=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
endmodule : tb_top
